// file: maint_irq_regs.vh
/*
 * Register map, field positions and reset values of the maintenance and
 * interrupt control block.
 * Assumes inclusion by bare name from the block's design file.
 */
`ifndef MAINT_IRQ_REGS_VH
`define MAINT_IRQ_REGS_VH

// printed offsets are register indices; byte address is four times the index
`define IDX_DEACT_PAT 8'h12
`define IDX_ERR_CTRL 8'h13
`define IDX_MASK_LINE 8'h14
`define IDX_MASK_ERR 8'h15
`define IDX_EDGE_SEL 8'h16
`define IDX_LINE_STAT 8'h17
`define IDX_CNT_LOW 8'h18
`define IDX_CNT_HIGH 8'h19
`define IDX_IRQ_STAT 8'h1A
`define IDX_IRQ_STAT_ERR 8'h1B
`define IDX_IRQ_CLR 8'h1C
`define IDX_IRQ_CLR_ERR 8'h1D
`define IDX_DEACT_LEN 8'h1E

`define RST_DEACT_PAT 8'h09
`define RST_DEACT_LEN 2'h1
`define RST_ERR_CTRL 8'h00
`define RST_MASK 8'hFF
`define RST_EDGE_SEL 8'h00

`define BIT_VIOL_INJ 6
`define BIT_PAT_INJ 5
`define BIT_EXZ_SEL 4
`define BIT_CSEL_HI 3
`define BIT_CSEL_LO 2
`define BIT_CNT_MODE 1
`define BIT_COUNT_TRANSFER 0

`define CSEL_PATTERN 2'h0
`define CSEL_EXZ 2'h1
`define CSEL_CV 2'h2
`define CSEL_CV_EXZ 2'h3

`define ADDR_IDX_MSB 11
`define ADDR_IDX_LSB 2
`define DATA_BYTE_MSB 7
`define LEN_MSB 1
`define DEACT_MIN_BITS 5
`define CNT_LOW_MSB 7
`define CNT_HIGH_MSB 15
`define CNT_HIGH_LSB 8
`define EVT_CNT_OVF 0
`define EVT_TICK 1

`define ERR_CTRL_WMASK 8'h7F
`endif

// file: maint_error_and_irq_control.v
/*
 * Maintenance control (deactivate code, error insertion, 16-bit error
 * counter) and interrupt masking/edge selection, reached over APB.
 * Assumes line status, error strobes and one-second tick are synchronous
 * to pclk; the datapaths consuming the control outputs live elsewhere.
 */
`timescale 1ns/1ps
`include "maint_irq_regs.vh"

module maint_error_and_irq_control #(
  parameter CNT_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] line_status_now,
  input wire [7:0] error_events,
  input wire err_pattern,
  input wire err_excess_zero,
  input wire err_code_violation,
  input wire second_tick,
  output wire [7:0] rx_deact_pattern,
  output wire [1:0] rx_deact_pattern_len,
  output wire [7:0] rx_deact_code_mask,
  output reg violation_inject,
  output reg pattern_error_inject,
  output wire excess_zero_rule_sel,
  output wire [1:0] error_count_sel,
  output wire count_report_mode,
  output wire irq
);

////////////////////////////////////////////////////////////////////////////
// apb decode

reg [7:0] deact_pat_r;
reg [1:0] deact_len_r;
reg [7:0] err_ctrl_r;
reg [7:0] mask_line_r;
reg [7:0] mask_err_r;
reg [7:0] edge_sel_r;
reg [7:0] stat_prev_r;
reg [7:0] pend_line_r;
reg [7:0] pend_err_r;
reg [CNT_W-1:0] count_r;
reg [CNT_W-1:0] result_r;
reg [7:0] result_high_r;

wire [9:0] idx;
wire wr_en;
wire rd_en;
wire known;
wire [7:0] wdat;

// byte lanes 1..3 and the two low address bits carry nothing
assign idx = paddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
assign wdat = pwdata[`DATA_BYTE_MSB:0];

// index window of this block; upper index bits must be zero so that
// an out-of-window address never aliases onto a live register
assign known = (idx >= {2'b00, `IDX_DEACT_PAT}) &&
  (idx <= {2'b00, `IDX_DEACT_LEN});

// zero wait states: every access phase completes at its first edge
assign pready = 1'b1;

// refused accesses neither write nor snapshot anything
assign wr_en = psel & penable & pwrite & known;
assign rd_en = psel & penable & ~pwrite & known;

assign pslverr = psel & penable & ~known;

////////////////////////////////////////////////////////////////////////////
// control registers

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    deact_pat_r <= `RST_DEACT_PAT;
    deact_len_r <= `RST_DEACT_LEN;
    err_ctrl_r <= `RST_ERR_CTRL;
    mask_line_r <= `RST_MASK;
    mask_err_r <= `RST_MASK;
    edge_sel_r <= `RST_EDGE_SEL;
  end else if (wr_en) begin
    case (idx[7:0])
      `IDX_DEACT_PAT: begin
        deact_pat_r <= wdat;
      end
      `IDX_DEACT_LEN: begin
        deact_len_r <= wdat[`LEN_MSB:0];
      end
      `IDX_ERR_CTRL: begin
        // reserved top bit always reads back as zero
        err_ctrl_r <= wdat & `ERR_CTRL_WMASK;
      end
      `IDX_MASK_LINE: begin
        mask_line_r <= wdat;
      end
      `IDX_MASK_ERR: begin
        mask_err_r <= wdat;
      end
      `IDX_EDGE_SEL: begin
        edge_sel_r <= wdat;
      end
      // live status, counts, pending and clear slots hold no state here
      default: begin
        deact_len_r <= deact_len_r;
      end
    endcase
  end
end

assign rx_deact_pattern = deact_pat_r;
assign rx_deact_pattern_len = deact_len_r;
assign excess_zero_rule_sel = err_ctrl_r[`BIT_EXZ_SEL];
assign error_count_sel = err_ctrl_r[`BIT_CSEL_HI:`BIT_CSEL_LO];
assign count_report_mode = err_ctrl_r[`BIT_CNT_MODE];

// compare window of the repeating deactivate code
genvar gi;
generate
  for (gi = 0; gi < 8; gi = gi + 1) begin : g_codemask
    if (gi < `DEACT_MIN_BITS) begin : g_always
      // the shortest code still spans five bits
      assign rx_deact_code_mask[gi] = 1'b1;
    end else begin : g_len
      // length code n keeps 5 + n low bits of the pattern
      assign rx_deact_code_mask[gi] =
        ({1'b0, deact_len_r} >= (gi - `DEACT_MIN_BITS + 1));
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////
// single-shot injection and counter transfer

reg [7:0] ctrl_prev_r;
wire viol_rise;
wire pat_rise;
wire trf_rise;
wire auto_trf;
reg err_inc;

assign viol_rise = err_ctrl_r[`BIT_VIOL_INJ] & ~ctrl_prev_r[`BIT_VIOL_INJ];
assign pat_rise = err_ctrl_r[`BIT_PAT_INJ] & ~ctrl_prev_r[`BIT_PAT_INJ];
assign trf_rise = err_ctrl_r[`BIT_COUNT_TRANSFER] & ~ctrl_prev_r[`BIT_COUNT_TRANSFER];
// auto report latches on each one-second tick
assign auto_trf = count_report_mode & second_tick;

// one increment per cycle at most: a code violation and an excess-zero
// error in the same cycle count once in the combined setting
always @* begin
  err_inc = 1'b0;
  case (error_count_sel)
    `CSEL_PATTERN: begin
      err_inc = err_pattern;
    end
    `CSEL_EXZ: begin
      err_inc = err_excess_zero;
    end
    `CSEL_CV: begin
      err_inc = err_code_violation;
    end
    `CSEL_CV_EXZ: begin
      err_inc = err_code_violation | err_excess_zero;
    end
    default: begin
      err_inc = 1'b0;
    end
  endcase
end

wire cnt_full;
wire cnt_ovf;
wire count_take;
assign count_take = trf_rise | auto_trf;
assign cnt_full = &count_r;
assign cnt_ovf = err_inc & cnt_full & ~count_take;

// rising-edge detectors on the software control bits
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    ctrl_prev_r <= `RST_ERR_CTRL;
  end else begin
    ctrl_prev_r <= err_ctrl_r;
  end
end

// one-cycle pulses; holding the bit high inserts nothing more
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    violation_inject <= 1'b0;
    pattern_error_inject <= 1'b0;
  end else begin
    violation_inject <= viol_rise;
    pattern_error_inject <= pat_rise;
  end
end

// error counter; a transfer wins over an increment in the same cycle
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    count_r <= {CNT_W{1'b0}};
  end else if (count_take) begin
    count_r <= {CNT_W{1'b0}};
  end else if (err_inc & ~cnt_full) begin
    // saturates rather than wrapping; overflow raises an event
    count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
  end
end

// result registers seen by software
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    result_r <= {CNT_W{1'b0}};
  end else if (count_take) begin
    result_r <= count_r;
  end
end

// high byte snapshot when low byte is read keeps the pair coherent
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    result_high_r <= 8'h00;
  end else if (rd_en && idx[7:0] == `IDX_CNT_LOW) begin
    result_high_r <= result_r[`CNT_HIGH_MSB:`CNT_HIGH_LSB];
  end
end

////////////////////////////////////////////////////////////////////////////
// interrupt events

wire [7:0] line_evt;
wire [7:0] err_evt;
wire [7:0] clr_line;
wire [7:0] clr_err;

assign clr_line = (wr_en && idx[7:0] == `IDX_IRQ_CLR) ? wdat : 8'h00;
assign clr_err = (wr_en && idx[7:0] == `IDX_IRQ_CLR_ERR) ? wdat : 8'h00;

wire [7:0] line_rise;
wire [7:0] line_fall;

generate
  for (gi = 0; gi < 8; gi = gi + 1) begin : g_evt
    // compared with the previous cycle's copy of the live status
    assign line_rise[gi] = line_status_now[gi] & ~stat_prev_r[gi];
    assign line_fall[gi] = ~line_status_now[gi] & stat_prev_r[gi];
    assign line_evt[gi] = ~mask_line_r[gi] &
      (line_rise[gi] | (edge_sel_r[gi] & line_fall[gi]));
    if (gi == `EVT_CNT_OVF) begin : g_ovf
      // counter overflow has no strobe pin of its own to rely on
      assign err_evt[gi] = ~mask_err_r[gi] & (error_events[gi] | cnt_ovf);
    end else if (gi == `EVT_TICK) begin : g_tick
      assign err_evt[gi] = ~mask_err_r[gi] &
        (error_events[gi] | second_tick);
    end else begin : g_plain
      assign err_evt[gi] = ~mask_err_r[gi] & error_events[gi];
    end
  end
endgenerate

// idle level of every status input is low, so zero after reset gives
// no false edge unless a condition is already present at release
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    stat_prev_r <= 8'h00;
  end else begin
    stat_prev_r <= line_status_now;
  end
end

// a new event wins over a clear in the same cycle
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pend_line_r <= 8'h00;
  end else begin
    pend_line_r <= (pend_line_r & ~clr_line) | line_evt;
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pend_err_r <= 8'h00;
  end else begin
    pend_err_r <= (pend_err_r & ~clr_err) | err_evt;
  end
end

// masking a source later also hides its pending bit from the pin
assign irq = |(pend_line_r & ~mask_line_r) |
  |(pend_err_r & ~mask_err_r);

////////////////////////////////////////////////////////////////////////////
// read data

// read mux is combinational; the byte is registered in the setup cycle
reg [7:0] rd_mux;

always @* begin
  rd_mux = 8'h00;
  case (idx[7:0])
    `IDX_DEACT_PAT: begin
      rd_mux = deact_pat_r;
    end
    `IDX_DEACT_LEN: begin
      rd_mux = {6'h00, deact_len_r};
    end
    `IDX_ERR_CTRL: begin
      rd_mux = err_ctrl_r;
    end
    `IDX_MASK_LINE: begin
      rd_mux = mask_line_r;
    end
    `IDX_MASK_ERR: begin
      rd_mux = mask_err_r;
    end
    `IDX_EDGE_SEL: begin
      rd_mux = edge_sel_r;
    end
    `IDX_LINE_STAT: begin
      rd_mux = line_status_now;
    end
    `IDX_CNT_LOW: begin
      rd_mux = result_r[`CNT_LOW_MSB:0];
    end
    `IDX_CNT_HIGH: begin
      rd_mux = result_high_r;
    end
    `IDX_IRQ_STAT: begin
      rd_mux = pend_line_r;
    end
    `IDX_IRQ_STAT_ERR: begin
      rd_mux = pend_err_r;
    end
    // clear slots are write-only and read as zero
    default: begin
      rd_mux = 8'h00;
    end
  endcase
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h00000000;
  end else if (psel & ~penable & ~pwrite) begin
    // refused reads return zero even where the low index bits alias
    if (known) begin
      prdata <= {24'h000000, rd_mux};
    end else begin
      prdata <= 32'h00000000;
    end
  end
end

endmodule // maint_error_and_irq_control

// file: maint_irq_checker.sv
/* checker: port-level properties of the maintenance/irq block.
   bound to the block's top module; reset is async, active low. */
`timescale 1ns/1ps
module maint_irq_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire [7:0] line_status_now,
  input wire [7:0] error_events,
  input wire err_pattern,
  input wire err_excess_zero,
  input wire err_code_violation,
  input wire second_tick,
  input wire [7:0] rx_deact_pattern,
  input wire [1:0] rx_deact_pattern_len,
  input wire [7:0] rx_deact_code_mask,
  input wire violation_inject,
  input wire pattern_error_inject,
  input wire [1:0] error_count_sel,
  input wire count_report_mode,
  input wire irq
);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [9:0] idx = paddr[11:2];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////
  slverr_map_a: assert property (
    acc |-> pslverr == (idx < 10'h12 || idx > 10'h1E)) else $error("slverr");
  code_mask_a: assert property (
    rx_deact_code_mask == ~(8'hE0 << rx_deact_pattern_len)) else $error("mask");
  viol_once_a: assert property (
    violation_inject |=> !violation_inject) else $error("viol long");
  pat_once_a: assert property (
    pattern_error_inject |=> !pattern_error_inject) else $error("perr long");
  viol_cause_a: assert property (
    $rose(violation_inject) |-> $past(wr && idx == 10'h13 && pwdata[6], 2))
    else $error("viol cause");
  pat_hold_a: assert property (
    $changed(rx_deact_pattern) |-> $past(wr && idx == 10'h12))
    else $error("pattern change");
  ctrl_hold_a: assert property (
    $changed({error_count_sel, count_report_mode}) |->
    $past(wr && idx == 10'h13)) else $error("ctrl change");
  irq_cause_a: assert property (
    $rose(irq) |-> $past(wr) || $past(|error_events) || $past(second_tick)
    || $past(err_pattern | err_excess_zero | err_code_violation)
    || $past(line_status_now) != $past(line_status_now, 2))
    else $error("irq cause");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(wr)) else $error("irq fall");
endmodule // maint_irq_checker
////////////////////////////////
bind maint_error_and_irq_control maint_irq_checker u_maint_irq_checker (.*);

// file: tb_maint_error_and_irq_control.sv
/* tb: self-checking APB bench for the maintenance/irq block.
   no partner model; bench drives status and error pulses itself. */
`timescale 1ns/1ps
module tb_maint_error_and_irq_control;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [7:0] line_status_now = 8'h00, error_events = 8'h00;
  reg err_pattern = 0, err_excess_zero = 0, err_code_violation = 0;
  reg second_tick = 0, serr;
  reg [31:0] rdat;
  wire [31:0] prdata;
  wire pready, pslverr, violation_inject, pattern_error_inject, irq;
  wire [7:0] rx_deact_pattern, rx_deact_code_mask;
  wire [1:0] rx_deact_pattern_len, error_count_sel;
  wire excess_zero_rule_sel, count_report_mode;
  integer fails = 0, check_count = 0, vc = 0, pc = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    vc <= vc + violation_inject;
    pc <= pc + pattern_error_inject;
  end
  maint_error_and_irq_control u_maint_error_and_irq_control (.*);
  ////////////////////////////////
  task automatic chk(input string n, input [31:0] s, input [31:0] e);
    check_count = check_count + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input [9:0] i, input w, input [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  task automatic rd(input [9:0] i, input [7:0] e, input string n);
    apb(i, 1'h0, 8'h00);
    chk(n, rdat, {24'h0, e});
  endtask
  task automatic pulses(input [2:0] m, input integer n);
    repeat (n) begin
      @(posedge pclk);
      {err_pattern, err_excess_zero, err_code_violation} <= m;
      @(posedge pclk);
      {err_pattern, err_excess_zero, err_code_violation} <= 3'h0;
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge pclk);
    #1;
  endtask
  ////////////////////////////////
  task t_reset;
    rd(10'h12, 8'h09, "pattern");
    rd(10'h13, 8'h00, "ctrl");
    rd(10'h14, 8'hFF, "mask line");
    rd(10'h15, 8'hFF, "mask err");
    rd(10'h16, 8'h00, "edge sel");
    rd(10'h1E, 8'h01, "length");
    chk("code mask", {24'h0, rx_deact_code_mask}, 32'h3F);
    $display("reset test done");
  endtask
  task t_len;
    integer i;
    for (i = 0; i < 4; i = i + 1) begin
      apb(10'h1E, 1'h1, i[7:0]);
      chk("code mask", {24'h0, rx_deact_code_mask}, 32'hFF >> (3 - i));
      chk("len out", {30'h0, rx_deact_pattern_len}, i);
    end
    apb(10'h12, 1'h1, 8'hA5);
    chk("pattern out", {24'h0, rx_deact_pattern}, 32'hA5);
    $display("length test done");
  endtask
  task t_inject;
    apb(10'h13, 1'h1, 8'h60);
    settle;
    apb(10'h13, 1'h1, 8'h60);
    settle;
    chk("viol once", vc, 1);
    chk("perr once", pc, 1);
    apb(10'h13, 1'h1, 8'h00);
    apb(10'h13, 1'h1, 8'hDC);
    settle;
    chk("viol again", vc, 2);
    rd(10'h13, 8'h5C, "ctrl");
    chk("exz rule", excess_zero_rule_sel, 1);
    chk("cnt sel", {30'h0, error_count_sel}, 3);
    $display("inject test done");
  endtask
  task t_count;
    apb(10'h13, 1'h1, 8'h00);
    pulses(3'h4, 3);
    pulses(3'h2, 2);
    apb(10'h13, 1'h1, 8'h01);
    settle;
    rd(10'h18, 8'h03, "count low");
    rd(10'h19, 8'h00, "count high");
    apb(10'h13, 1'h1, 8'h04);
    pulses(3'h2, 2);
    pulses(3'h1, 1);
    apb(10'h13, 1'h1, 8'h05);
    settle;
    rd(10'h18, 8'h02, "count exz");
    apb(10'h13, 1'h1, 8'h0A);
    chk("cnt mode", count_report_mode, 1);
    pulses(3'h1, 4);
    @(posedge pclk) second_tick <= 1'h1;
    @(posedge pclk) second_tick <= 1'h0;
    settle;
    rd(10'h18, 8'h04, "count auto");
    $display("count test done");
  endtask
  task t_irq;
    apb(10'h14, 1'h1, 8'hFE);
    @(posedge pclk) line_status_now <= 8'h09;
    settle;
    chk("irq rise", irq, 1);
    rd(10'h1A, 8'h01, "pend line");
    rd(10'h17, 8'h09, "live status");
    apb(10'h1C, 1'h1, 8'h01);
    @(posedge pclk) line_status_now <= 8'h00;
    settle;
    chk("irq fall edge", irq, 0);
    apb(10'h16, 1'h1, 8'h01);
    @(posedge pclk) line_status_now <= 8'h01;
    settle;
    apb(10'h1C, 1'h1, 8'h01);
    @(posedge pclk) line_status_now <= 8'h00;
    settle;
    chk("irq both edges", irq, 1);
    apb(10'h1C, 1'h1, 8'h01);
    apb(10'h15, 1'h1, 8'hFB);
    @(posedge pclk) error_events <= 8'h04;
    @(posedge pclk) error_events <= 8'h00;
    settle;
    rd(10'h1B, 8'h04, "pend err");
    apb(10'h15, 1'h1, 8'hF9);
    @(posedge pclk) second_tick <= 1'h1;
    @(posedge pclk) second_tick <= 1'h0;
    settle;
    rd(10'h1B, 8'h06, "tick event");
    apb(10'h15, 1'h1, 8'hFF);
    chk("irq masked", irq, 0);
    rd(10'h30, 8'h00, "unmapped");
    chk("slverr", serr, 1);
    apb(10'h312, 1'h1, 8'h00);
    chk("alias slverr", serr, 1);
    rd(10'h12, 8'hA5, "alias kept");
    $display("irq test done");
  endtask
  ////////////////////////////////
  task stop_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_len;
    t_inject;
    t_count;
    t_irq;
    stop_test;
  end
  initial begin
    #200000;
    fails = fails + 1;
    stop_test;
  end
endmodule // tb_maint_error_and_irq_control
